// *** logic/lfo_pkg.sv ***
// Constants and types shared by the per-voice LFO modulator
package lfo_pkg;
   // Register byte offsets (one 32-bit word each)
   localparam logic [7:0] CFG0_OFFSET   = 8'h00; // Pitch LFO setup
   localparam logic [7:0] DEPTH0_OFFSET = 8'h04; // Pitch LFO depths
   localparam logic [7:0] LFO_STRIDE    = 8'h08; // Step to next LFO
   localparam logic [7:0] STATUS_OFFSET = 8'h18; // Shared phases
   // Setup word field positions
   localparam int WAVE_LSB  = 0;  // 3-bit waveform
   localparam int TRIG_LSB  = 3;  // 2-bit trigger setting
   localparam int SPEED_LSB = 8;  // 7-bit speed
   localparam int DELAY_LSB = 16; // 7-bit fade-in delay
   localparam int LEVEL_LSB = 24; // 7-bit base level
   // Depth word field positions
   localparam int WHEEL_LSB  = 0;  // Signed wheel depth
   localparam int AFTER_LSB  = 8;  // Signed aftertouch depth
   localparam int DEST_LSB   = 16; // Signed destination depth
   localparam int MATRIX_BIT = 24; // Used as matrix source
   // Reset values
   localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
   localparam logic [31:0] DEPTH_RESET = 32'h0000_0000;
   localparam logic [15:0] LFSR_SEED   = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS   = 16'hB400;
   // Parameter ceiling for speed, delay, level and depths
   localparam logic [6:0] PARAM_MAX = 7'h63;
   // Number of LFOs per voice
   localparam int NUM_LFO = 3;
   // Waveform selector codes
   typedef enum logic [2:0] {
      W_SINE     = 3'b000,
      W_TRI      = 3'b001,
      W_SQUARE   = 3'b010,
      W_SAW_UP   = 3'b011,
      W_SAW_DOWN = 3'b100,
      W_RAND_BI  = 3'b101,
      W_NOISE    = 3'b110,
      W_RAND_POS = 3'b111
   } wave_type;
   // Trigger setting codes
   typedef enum logic [1:0] {
      T_MONO     = 2'b00,
      T_POLY     = 2'b01,
      T_KEY_MONO = 2'b10,
      T_KEY_POLY = 2'b11
   } trig_type;
endpackage

// *** logic/lfo_modulator.sv ***
// Per-voice pitch, filter and amplitude LFOs with an APB register file
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps

module lfo_modulator #(
   parameter int NUM_VOICES = 4,                // Voices served
   parameter int PW         = 24,               // Phase width
   parameter int FW         = 16,               // Fade counter width
   parameter int VW         = $clog2(NUM_VOICES) // Voice index width
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    ce,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    sample_tick,
   input  wire logic                    note_on,
   input  wire logic [VW-1:0]           note_voice,
   input  wire logic [6:0]              mod_wheel,
   input  wire logic [6:0]              aftertouch,
   input  wire logic signed [7:0]       global_speed_mod,
   input  wire logic [NUM_VOICES*8-1:0] voice_speed_mod,
   input  wire logic [VW-1:0]           out_voice,
   output logic signed [15:0]           pitch_lfo,
   output logic signed [15:0]           filter_lfo,
   output logic signed [15:0]           amp_lfo
);
   localparam int V = NUM_VOICES;
   localparam int L = lfo_pkg::NUM_LFO;

   // All state of the block; slot V of phase and hold is the shared one
   typedef struct packed {
      logic [L-1:0][31:0]             cfg;   // Setup words
      logic [L-1:0][31:0]             depth; // Depth words
      logic [L-1:0][V:0][PW-1:0]      phase; // Phase accumulators
      logic [L-1:0][V:0][7:0]         hold;  // Random sample-and-hold
      logic [L-1:0][V-1:0][FW-1:0]    fade;  // Fade-in counters
      logic [15:0]                    lfsr;  // Random source
      logic [31:0]                    rdata; // Read data
      logic                           ready; // Access answer
      logic                           slverr;// Refused access: unmapped, or status write
      logic [L-1:0][15:0]             out;   // Modulation outputs
   } state_type;

   state_type s;      // Current state
   state_type next_s; // Next state

   // Fields are clamped as they are written, so the datapath never sees a
   // value outside the legal range and needs no second clamp per cycle.
   // Software reading back a field sees the value actually in force.
   // Clamp a signed value into 0..99
   function automatic logic [6:0] clamp99(input logic signed [9:0] x);
      if (x < 10'sd0) begin
         return 7'h00;
      end else if (x > $signed({3'h0, lfo_pkg::PARAM_MAX})) begin
         return lfo_pkg::PARAM_MAX;
      end
      return x[6:0];
   endfunction

   // Clamp a signed depth into -99..99
   function automatic logic [7:0] sclamp99(input logic signed [7:0] x);
      if (x > $signed({1'b0, lfo_pkg::PARAM_MAX})) begin
         return {1'b0, lfo_pkg::PARAM_MAX};
      end else if (x < -$signed({1'b0, lfo_pkg::PARAM_MAX})) begin
         return -{1'b0, lfo_pkg::PARAM_MAX};
      end
      return x;
   endfunction

   // A quadratic step gives fine control at slow rates and still reaches
   // fast rates at the top of the range; a linear map would crowd all the
   // useful slow settings into the first few codes.
   // Square of (c + 1): phase step for speed and fade step for delay
   function automatic logic [15:0] sq(input logic [6:0] c);
      logic [15:0] k;
      k = 16'(c) + 16'h0001;
      return k * k;
   endfunction

   // Only the top byte of the phase is used for shaping, which keeps the
   // multipliers small. Bipolar shapes swing about zero; unipolar shapes
   // stay at or above zero so they only push the destination one way.
   // The held random value changes once per cycle of its own phase.
   // Waveform value from the phase byte, held random and noise byte
   function automatic logic signed [9:0] wave_val(input logic [2:0] w,
         input logic [7:0] u, input logic [7:0] hld, input logic [7:0] nz);
      logic [13:0] hump;
      hump = 14'(u[6:0]) * (14'h007F - 14'(u[6:0]));
      case (lfo_pkg::wave_type'(w))
         // Parabolic half-cycles, bipolar
         lfo_pkg::W_SINE: begin
            wave_val = u[7] ? -$signed(10'(hump[13:5]))
                            : $signed(10'(hump[13:5]));
         end
         // Bipolar triangle
         lfo_pkg::W_TRI: begin
            wave_val = u[7] ? $signed(10'h17F - (10'(u) << 1))
                            : $signed((10'(u) << 1) - 10'h080);
         end
         // Bipolar square
         lfo_pkg::W_SQUARE: begin
            wave_val = u[7] ? -10'sd127 : 10'sd127;
         end
         // Unipolar rising saw
         lfo_pkg::W_SAW_UP: begin
            wave_val = $signed(10'(u));
         end
         // Unipolar falling saw
         lfo_pkg::W_SAW_DOWN: begin
            wave_val = $signed(10'(8'hFF - u));
         end
         // Bipolar held random
         lfo_pkg::W_RAND_BI: begin
            wave_val = 10'($signed(hld));
         end
         // Bipolar noise
         lfo_pkg::W_NOISE: begin
            wave_val = 10'($signed(nz));
         end
         // Unipolar held random
         default: begin
            wave_val = $signed(10'(hld));
         end
      endcase
   endfunction

   // The contributions are summed first and clamped once, so a negative
   // depth can only take away what the level or the other controller gave.
   // Clamping each term on its own would let a negative wheel cancel
   // nothing at all when aftertouch was raising the level.
   // Effective amplitude from level, wheel and aftertouch
   function automatic logic [6:0] amp_of(input logic [31:0] cw,
         input logic [31:0] dw, input logic [6:0] wh, input logic [6:0] at);
      logic signed [15:0] sum;
      sum = $signed({9'h000, cw[lfo_pkg::LEVEL_LSB +: 7]})
          + ((16'($signed(dw[lfo_pkg::WHEEL_LSB +: 8]))
              * $signed({9'h000, wh})) >>> 7)
          + ((16'($signed(dw[lfo_pkg::AFTER_LSB +: 8]))
              * $signed({9'h000, at})) >>> 7);
      if (sum < 16'sd0) begin
         return 7'h00;
      end else if (sum > $signed({9'h000, lfo_pkg::PARAM_MAX})) begin
         return lfo_pkg::PARAM_MAX;
      end
      return sum[6:0];
   endfunction

   // Next-state logic: bus, oscillators, fade-in and output stage
   always_comb begin
      int sl;                     // Phase slot read for the output
      logic mono;                 // Shared-phase trigger setting
      logic [PW:0] sum;           // Phase sum with carry
      logic [FW:0] fsum;          // Fade sum with carry
      logic [6:0] spd;            // Effective speed
      logic [6:0] dly;            // Delay setting
      logic [7:0] g;              // Fade gain
      logic signed [31:0] prod;   // Scaled output
      logic [1:0] trig;           // Trigger field
      sl = 0;
      mono = 1'b0;
      sum = '0;
      fsum = '0;
      spd = 7'h00;
      dly = 7'h00;
      g = 8'h00;
      prod = 32'sh0;
      trig = 2'b00;
      next_s = s;
      next_s.ready = 1'b0;
      next_s.slverr = 1'b0;
      // The ready flop blocks its own cause: while it is high the same
      // access phase is not taken again, so a master that holds the
      // request through the answer cycle gets exactly one transfer.
      // The error flop is only ever high together with ready.
      // APB access: answer one cycle into the access phase
      if (psel && penable && !s.ready) begin
         next_s.ready = 1'b1;
         next_s.slverr = 1'b1;
         next_s.rdata = 32'h0000_0000;
         if (paddr == lfo_pkg::STATUS_OFFSET) begin
            next_s.slverr = pwrite;
            for (int l = 0; l < L; l++) begin
               next_s.rdata[l*8 +: 8] = s.phase[l][V][PW-1 -: 8];
            end
         end
         for (int l = 0; l < L; l++) begin
            if (paddr == lfo_pkg::CFG0_OFFSET
                  + 8'(l) * lfo_pkg::LFO_STRIDE) begin
               next_s.slverr = 1'b0;
               next_s.rdata = s.cfg[l];
               if (pwrite) begin
                  // Store with out-of-range fields pulled into 0..99
                  next_s.cfg[l] = 32'h0000_0000;
                  next_s.cfg[l][lfo_pkg::WAVE_LSB +: 5] =
                     pwdata[lfo_pkg::WAVE_LSB +: 5];
                  next_s.cfg[l][lfo_pkg::SPEED_LSB +: 7] = clamp99(
                     $signed({3'h0, pwdata[lfo_pkg::SPEED_LSB +: 7]}));
                  next_s.cfg[l][lfo_pkg::DELAY_LSB +: 7] = clamp99(
                     $signed({3'h0, pwdata[lfo_pkg::DELAY_LSB +: 7]}));
                  next_s.cfg[l][lfo_pkg::LEVEL_LSB +: 7] = clamp99(
                     $signed({3'h0, pwdata[lfo_pkg::LEVEL_LSB +: 7]}));
               end
            end else if (paddr == lfo_pkg::DEPTH0_OFFSET
                  + 8'(l) * lfo_pkg::LFO_STRIDE) begin
               next_s.slverr = 1'b0;
               next_s.rdata = s.depth[l];
               if (pwrite) begin
                  next_s.depth[l] = 32'h0000_0000;
                  next_s.depth[l][lfo_pkg::MATRIX_BIT] =
                     pwdata[lfo_pkg::MATRIX_BIT];
                  next_s.depth[l][lfo_pkg::WHEEL_LSB +: 8] =
                     sclamp99(pwdata[lfo_pkg::WHEEL_LSB +: 8]);
                  next_s.depth[l][lfo_pkg::AFTER_LSB +: 8] =
                     sclamp99(pwdata[lfo_pkg::AFTER_LSB +: 8]);
                  next_s.depth[l][lfo_pkg::DEST_LSB +: 8] =
                     sclamp99(pwdata[lfo_pkg::DEST_LSB +: 8]);
               end
            end
         end
      end
      // Shared by all LFOs; each slot samples it only at its own phase wrap,
      // so voices whose phases wrap on different cycles hold different values.
      // Random source steps every enabled cycle
      next_s.lfsr = s.lfsr[0] ? ((s.lfsr >> 1) ^ lfo_pkg::LFSR_TAPS)
                              : (s.lfsr >> 1);
      // Three LFOs, each with a shared slot and one slot per voice
      for (int l = 0; l < L; l++) begin
         trig = s.cfg[l][lfo_pkg::TRIG_LSB +: 2];
         mono = (trig == lfo_pkg::T_MONO)
             || (trig == lfo_pkg::T_KEY_MONO);
         dly = s.cfg[l][lfo_pkg::DELAY_LSB +: 7];
         if (sample_tick) begin
            // Shared phase hears only global speed modulation
            spd = clamp99($signed({3'h0, s.cfg[l][lfo_pkg::SPEED_LSB +: 7]})
                  + 10'(global_speed_mod));
            sum = {1'b0, s.phase[l][V]} + (PW+1)'(sq(spd));
            next_s.phase[l][V] = sum[PW-1:0];
            if (sum[PW]) begin
               next_s.hold[l][V] = s.lfsr[7:0];
            end
            for (int v = 0; v < V; v++) begin
               // Own phase adds the voice's speed modulation
               spd = clamp99($signed({3'h0,
                     s.cfg[l][lfo_pkg::SPEED_LSB +: 7]})
                     + 10'(global_speed_mod)
                     + 10'($signed(voice_speed_mod[v*8 +: 8])));
               sum = {1'b0, s.phase[l][v]} + (PW+1)'(sq(spd));
               next_s.phase[l][v] = sum[PW-1:0];
               if (sum[PW]) begin
                  next_s.hold[l][v] = s.lfsr[7:0];
               end
               // Fade-in; zero delay opens the output fully at the next sample tick
               fsum = {1'b0, s.fade[l][v]}
                    + (FW+1)'(sq(lfo_pkg::PARAM_MAX - dly));
               if (dly == 7'h00 || fsum[FW]) begin
                  next_s.fade[l][v] = '1;
               end else begin
                  next_s.fade[l][v] = fsum[FW-1:0];
               end
            end
         end
         // A note that lands on a tick must still start from zero, otherwise
         // the first cycle after a retrigger would begin one step late.
         // Poly without key restart keeps the phase and only reopens fade.
         // Note start wins over the tick update
         if (note_on) begin
            next_s.fade[l][note_voice] = '0;
            if (trig == lfo_pkg::T_KEY_POLY) begin
               next_s.phase[l][note_voice] = '0;
            end else if (trig == lfo_pkg::T_KEY_MONO) begin
               next_s.phase[l][V] = '0;
            end
         end
         // The fade gain is the top byte of the voice's fade counter, so a
         // freshly started note is silent and grows as the counter rises.
         // Fade stays per voice even in the shared-phase settings, since
         // each note must fade in from its own start.
         // Output for the voice the engine is asking about
         sl = mono ? V : int'(out_voice);
         g = s.fade[l][out_voice][FW-1 -: 8];
         prod = 32'(wave_val(s.cfg[l][lfo_pkg::WAVE_LSB +: 3],
                      s.phase[l][sl][PW-1 -: 8], s.hold[l][sl],
                      s.lfsr[15:8]))
              * $signed({25'h0, amp_of(s.cfg[l], s.depth[l],
                      mod_wheel, aftertouch)})
              * $signed({24'h0, g});
         if (s.depth[l][lfo_pkg::DEST_LSB +: 8] != 8'h00
               || s.depth[l][lfo_pkg::MATRIX_BIT]) begin
            next_s.out[l] = 16'(prod >>> 8);
         end else begin
            next_s.out[l] = 16'h0000;
         end
      end
   end

   // Reset loads constants only; the register file comes up with every
   // output gated off because all depth words read zero.
   // The clock enable also stalls the bus answer, so a master must wait.
   // State register; clock enable low freezes everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         for (int l = 0; l < L; l++) begin
            s.cfg[l] <= lfo_pkg::CFG_RESET;
            s.depth[l] <= lfo_pkg::DEPTH_RESET;
         end
         s.lfsr <= lfo_pkg::LFSR_SEED;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register; no gate sits between a
   // flop and a port, so the engine sees glitch-free values.
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.slverr;
   assign pitch_lfo = s.out[0];
   assign filter_lfo = s.out[1];
   assign amp_lfo = s.out[2];
endmodule

// *** test/lfo_modulator_properties.sv ***
// Bus-side and clock-enable freeze assertions for the LFO modulator, bound to its ports
`timescale 1ns/1ps
module lfo_modulator_checker (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               ce,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic signed [15:0] pitch_lfo,
   input wire logic signed [15:0] amp_lfo
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Access phase accepted by the slave
   sequence taken_s;
      psel && penable && !pready && ce;
   endsequence
   // Accepted access above the top register
   sequence unmapped_s;
      taken_s ##0 (paddr > 8'h18);
   endsequence
   ready_follows_a: assert property (taken_s |=> pready)
      else $error("ready missing after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_cause_a: assert property (pready |-> $past(psel && penable && ce))
      else $error("ready without access");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   unmapped_err_a: assert property (unmapped_s |=> pslverr)
      else $error("unmapped access not refused");
   unmapped_zero_a: assert property (unmapped_s ##0 !pwrite |=> prdata == 0)
      else $error("unmapped read not zero");
   status_ro_a: assert property
      (taken_s ##0 (pwrite && paddr == 8'h18) |=> pslverr)
      else $error("status write not refused");
   mapped_ok_a: assert property (taken_s ##0 (paddr <= 8'h18 &&
      paddr[1:0] == 2'b00 && !(pwrite && paddr == 8'h18)) |=> !pslverr)
      else $error("mapped access refused");
   freeze_a: assert property (!ce |=> $stable(pitch_lfo) &&
      $stable(amp_lfo) && $stable(prdata))
      else $error("outputs moved with clock enable low");
endmodule
bind lfo_modulator lfo_modulator_checker chk (.pclk(pclk), .presetn(presetn),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pitch_lfo(pitch_lfo), .amp_lfo(amp_lfo));

// *** test/voice_engine_model.sv ***
// Voice engine model: walks the voices and notes any nonzero pitch value
`timescale 1ns/1ps
module voice_engine_model #(
   parameter int VW = 2 // Voice index width
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               clear,
   input  wire logic signed [15:0] pitch_lfo,
   output logic        [VW-1:0]    out_voice,
   output logic                    seen
);
   // Visit every voice in turn so each voice's own LFO is consumed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_voice <= '0;
         seen      <= 1'b0;
      end else begin
         out_voice <= out_voice + 1'b1;
         // Sticky flag until the bench clears it
         if (clear)
            seen <= 1'b0;
         else if (pitch_lfo != 16'sh0000)
            seen <= 1'b1;
      end
   end
endmodule

// *** test/per_voice_lfo_modulator_tb_top.sv ***
// Self-checking bench for the per-voice LFO modulator
`timescale 1ns/1ps
module per_voice_lfo_modulator_tb_top;
   logic               pclk, presetn, ce, psel, penable, pwrite;
   logic               sample_tick, note_on, clear, pready, pslverr, seen;
   logic        [7:0]  paddr;
   logic        [31:0] pwdata, prdata;
   logic        [1:0]  note_voice, out_voice;
   logic        [6:0]  mod_wheel, aftertouch;
   logic signed [7:0]  global_speed_mod;
   logic        [31:0] voice_speed_mod;
   logic signed [15:0] pitch_lfo, filter_lfo, amp_lfo;
   int                 fails, checked;
   lfo_modulator dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_tick(sample_tick), .note_on(note_on), .note_voice(note_voice),
      .mod_wheel(mod_wheel), .aftertouch(aftertouch),
      .global_speed_mod(global_speed_mod), .voice_speed_mod(voice_speed_mod),
      .out_voice(out_voice), .pitch_lfo(pitch_lfo), .filter_lfo(filter_lfo),
      .amp_lfo(amp_lfo));
   voice_engine_model #(.VW(2)) engine (.pclk(pclk), .presetn(presetn),
      .clear(clear), .pitch_lfo(pitch_lfo), .out_voice(out_voice),
      .seen(seen));
   // Clock of 5 ns period
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Verdict and end of run
   task automatic report_and_stop();
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Compare a word result
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Compare a flag result
   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Write, expecting the given error flag
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      cmp_bit(e, exp_err);
   endtask
   // Read and compare data and error flag
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
      input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      cmp_word(r, exp);
      cmp_bit(e, exp_err);
   endtask
   // Sample tick pulses, one every other cycle
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         sample_tick <= 1'b1;
         @(posedge pclk);
         sample_tick <= 1'b0;
      end
   endtask
   // Note start pulse for voice v
   task automatic note(input logic [1:0] v);
      @(posedge pclk);
      note_on <= 1'b1;
      note_voice <= v;
      @(posedge pclk);
      note_on <= 1'b0;
   endtask
   // All registers of the three LFOs read zero after reset
   task automatic t_reset();
      for (int a = 0; a <= 24; a += 4)
         rd_chk(a[7:0], 32'h0000_0000, 1'b0);
      cmp_word(32'(filter_lfo), 32'h0000_0000);
      cmp_word(32'(amp_lfo), 32'h0000_0000);
   endtask
   // Field clamping and every trigger and waveform code
   task automatic t_fields();
      wr(8'h08, 32'hFFFF_FFFF, 1'b0);
      rd_chk(8'h08, 32'h6363_631F, 1'b0);
      wr(8'h0C, 32'h0180_7F80, 1'b0);
      rd_chk(8'h0C, 32'h019D_639D, 1'b0);
      for (int i = 0; i < 32; i++) begin
         wr(8'h10, 32'(i), 1'b0);
         rd_chk(8'h10, 32'(i), 1'b0);
      end
   endtask
   // Refused accesses
   task automatic t_errors();
      rd_chk(8'h1C, 32'h0000_0000, 1'b1);
      wr(8'h18, 32'h1234_5678, 1'b1);
      wr(8'h40, 32'h0000_0001, 1'b1);
      rd_chk(8'h40, 32'h0000_0000, 1'b1);
   endtask
   // Shared phase: speed 50 plus global 49 gives 10000 per tick
   task automatic t_phase();
      global_speed_mod <= 8'sd49;
      voice_speed_mod <= 32'hCECE_CECE;
      wr(8'h00, 32'h0000_3210, 1'b0);
      note(2'd1);
      rd_chk(8'h18, 32'h0000_0000, 1'b0);
      ticks(10);
      rd_chk(8'h18, 32'h0000_0101, 1'b0);
      ce <= 1'b0;
      ticks(3);
      ce <= 1'b1;
      note(2'd2);
      rd_chk(8'h18, 32'h0000_0100, 1'b0);
      wr(8'h00, 32'h0000_3200, 1'b0);
      ticks(10);
      note(2'd3);
      rd_chk(8'h18, 32'h0000_0301, 1'b0);
      ticks(5);
      rd_chk(8'h18, 32'h0000_0302, 1'b0);
   endtask
   // One output gating case: square wave, speed 99, delay 0
   task automatic gate_case(input logic [31:0] cfg, input logic [31:0] dep,
      input logic [6:0] w, input logic [6:0] at, input logic exp);
      wr(8'h00, cfg, 1'b0);
      wr(8'h04, dep, 1'b0);
      mod_wheel <= w;
      aftertouch <= at;
      @(posedge pclk);
      clear <= 1'b1;
      @(posedge pclk);
      clear <= 1'b0;
      ticks(20);
      cmp_bit(seen, exp);
   endtask
   // Destination gating, base level and controller amounts
   task automatic t_gate();
      gate_case(32'h6300_6302, 32'h0000_0000, 7'h00, 7'h00, 1'b0);
      gate_case(32'h6300_6302, 32'h0040_0000, 7'h00, 7'h00, 1'b1);
      gate_case(32'h6300_6302, 32'h0100_0000, 7'h00, 7'h00, 1'b1);
      gate_case(32'h0000_6302, 32'h0040_009D, 7'h7F, 7'h00, 1'b0);
      gate_case(32'h0000_6302, 32'h0040_0063, 7'h7F, 7'h00, 1'b1);
      gate_case(32'h0000_6302, 32'h0040_6300, 7'h00, 7'h7F, 1'b1);
   endtask
   // Hang guard
   initial begin
      #200000;
      fails++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, sample_tick, note_on, clear} = '0;
      ce = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      note_voice = 2'd0;
      mod_wheel = 7'h00;
      aftertouch = 7'h00;
      global_speed_mod = 8'sd0;
      voice_speed_mod = 32'h0000_0000;
      fails = 0;
      checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_fields();
      t_errors();
      t_phase();
      t_gate();
      report_and_stop();
   end
endmodule
